/* pdec_pin_model.sv */
// Purpose : Far-side model of the interrupt pin and the port-two wake pins
// Assumes : Bench asks for pin levels; the model moves the pins just after an edge
// Notes   : A lag of zero answers promptly, a larger lag answers slowly
module pdec_pin_model
    import pdec_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nmi_req_b,
    input  wire logic [PDEC_WAKE_W-1:0] wake_req,
    input  wire logic [3:0]             lag,
    output      logic                   nmi_b,
    output      logic [PDEC_WAKE_W-1:0] wake
);
    logic [3:0] wait_q;

    initial begin
        nmi_b  = 1'b1;
        wake   = '0;
        wait_q = 4'h0;
    end

    // Pins move only after the lag, so the block never sees a request early
    always @(posedge clk) begin
        if (nmi_req_b !== nmi_b || wake_req !== wake) begin
            if (wait_q >= lag) begin
                nmi_b  <= #1 nmi_req_b;
                wake   <= #1 wake_req;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // pdec_pin_model

/* pdec_pkg.sv */
// Purpose : Shared constants and types for the power-down entry control block
// Assumes : One clock REF_CLK at 100 MHz, asynchronous active-low reset
// Notes   : Port-two wake pin count and defaults live here
package pdec_pkg;

    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int          PDEC_WAKE_W        = 16;
    localparam logic [15:0] PDEC_WAKE_EN_RST   = 16'h0000;
    localparam logic [15:0] PDEC_WAKE_POL_RST  = 16'hffff;
    localparam int          PDEC_SYNC_STAGES   = 2;

    // ****************************************
    // Exit source select encoding
    // ****************************************
    localparam logic        PDEC_SRC_NMI       = 1'b0;
    localparam logic        PDEC_SRC_PORT2     = 1'b1;

    // ****************************************
    // Tristate wait control: 0 means the tristate wait state is active
    // ****************************************
    localparam logic        PDEC_MTTW_ACTIVE   = 1'b0;

    typedef enum logic [1:0] {
        PDEC_RUN,
        PDEC_QUASI_IDLE,
        PDEC_POWER_DOWN
    } pdec_state_t;

endpackage : pdec_pkg

/* pdec_power_down_entry.sv */
// Purpose : Decides whether a power-down instruction enters power-down
// Assumes : CPU pipeline supplies one-cycle execute pulse and fetch context
// Notes   : FIXED_STEP=0 models the faulty step with its quasi-idle state
//
// Contract
// [RULE_01] Select clear, interrupt pin high: no entry
// [RULE_02] Select set, enabled wake pin active: no entry
// [RULE_03] Blocked instruction ignored, execution continues
// [RULE_04] Otherwise power-down is entered normally
// [RULE_05] Blocked, external muxed tristate-wait code: quasi-idle
// [RULE_06] Blocked after external write, external code: quasi-idle
// [RULE_07] Quasi-idle keeps peripherals and watchdog running
// [RULE_08] Quasi-idle blocks interrupts and event transfers
// [RULE_09] Interrupt pin low in quasi-idle enters power-down
// [RULE_10] Fixed step never enters quasi-idle
module pdec_power_down_entry
    import pdec_pkg::*;
#(
    parameter int   WAKE_W     = PDEC_WAKE_W,
    parameter logic FIXED_STEP = 1'b0
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    input  wire logic              POWER_DOWN_INSTRUCTION,
    input  wire logic              EXIT_SOURCE_SELECT,
    input  wire logic              NMI_B,
    input  wire logic [WAKE_W-1:0] PORT_TWO_WAKE_PINS,
    input  wire logic [WAKE_W-1:0] WAKE_PIN_ENABLE,
    input  wire logic [WAKE_W-1:0] WAKE_PIN_ACTIVE_HIGH,
    input  wire logic              NEXT_CODE_EXTERNAL,
    input  wire logic              BUS_MULTIPLEXED,
    input  wire logic              MUX_TRISTATE_WAIT_CTRL,
    input  wire logic              PREV_EXTERNAL_WRITE,
    input  wire logic              WATCHDOG_OVERFLOW,
    input  wire logic              WATCHDOG_ENABLE,
    output      logic              POWER_DOWN,
    output      logic              QUASI_IDLE,
    output      logic              FETCH_ENABLE,
    output      logic              INSTR_IGNORED,
    output      logic              IRQ_SERVICE_ENABLE,
    output      logic              PERIPHERAL_TRANSFER_ENABLE,
    output      logic              PERIPHERAL_CLOCK_ENABLE,
    output      logic              WATCHDOG_RESET
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic              nmi_b_s;
    logic [WAKE_W-1:0] wake_s;

    // Synchroniser reset words are 16 bits wide
    if (WAKE_W < 1 || WAKE_W > 16) begin : g_bad_wake_w
        $error("pdec: WAKE_W must be 1..16");
    end

    pdec_sync #(.W(1), .RST(16'h0001)) u_sync_nmi (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .din   (NMI_B),
        .dout  (nmi_b_s)
    );

    pdec_sync #(.W(WAKE_W), .RST(16'h0000)) u_sync_wake (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .din   (PORT_TWO_WAKE_PINS),
        .dout  (wake_s)
    );

    // ****************************************
    // Entry decision
    // ****************************************
    logic        wake_any;
    logic        blocked;
    logic        stall_fault;
    pdec_state_t state_q;
    pdec_state_t state_d;
    logic        ignored_q;
    logic        ignored_d;

    // A pin is active when it matches its chosen polarity
    assign wake_any = |(WAKE_PIN_ENABLE & ~(wake_s ^ WAKE_PIN_ACTIVE_HIGH));

    always_comb begin
        if (EXIT_SOURCE_SELECT == PDEC_SRC_NMI) begin
            blocked = nmi_b_s;  // RULE_01
        end else begin
            blocked = wake_any; // RULE_02
        end
    end

    always_comb begin
        stall_fault = 1'b0;
        if (!FIXED_STEP && NEXT_CODE_EXTERNAL) begin
            if (BUS_MULTIPLEXED && MUX_TRISTATE_WAIT_CTRL == PDEC_MTTW_ACTIVE) begin
                stall_fault = 1'b1; // RULE_05
            end
            if (PREV_EXTERNAL_WRITE) begin
                stall_fault = 1'b1; // RULE_06
            end
        end
    end

    always_comb begin
        state_d   = state_q;
        ignored_d = 1'b0;
        case (state_q)
            PDEC_RUN: begin
                if (POWER_DOWN_INSTRUCTION) begin
                    if (!blocked) begin
                        state_d = PDEC_POWER_DOWN; // RULE_04
                    end else if (stall_fault) begin
                        state_d = PDEC_QUASI_IDLE; // RULE_05
                    end else begin
                        ignored_d = 1'b1; // RULE_03 RULE_10
                    end
                end
            end
            PDEC_QUASI_IDLE: begin
                if (!nmi_b_s) begin
                    state_d = PDEC_POWER_DOWN; // RULE_09
                end
            end
            PDEC_POWER_DOWN: begin
                // Left only by reset; wake-up exit belongs to the clock block
                state_d = PDEC_POWER_DOWN;
            end
            default: begin
                state_d = PDEC_RUN;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q   <= PDEC_RUN;
            ignored_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            ignored_q <= ignored_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign POWER_DOWN                 = (state_q == PDEC_POWER_DOWN);
    assign QUASI_IDLE                 = (state_q == PDEC_QUASI_IDLE);
    assign FETCH_ENABLE               = (state_q == PDEC_RUN); // RULE_03
    assign INSTR_IGNORED              = ignored_q;
    assign IRQ_SERVICE_ENABLE         = (state_q == PDEC_RUN); // RULE_08
    assign PERIPHERAL_TRANSFER_ENABLE = (state_q == PDEC_RUN); // RULE_08
    // Peripherals stay clocked in quasi-idle, so the watchdog can still rescue it
    assign PERIPHERAL_CLOCK_ENABLE    = (state_q != PDEC_POWER_DOWN); // RULE_07
    assign WATCHDOG_RESET             = WATCHDOG_ENABLE & WATCHDOG_OVERFLOW
                                        & (state_q != PDEC_POWER_DOWN); // RULE_07

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_pd_request;
        POWER_DOWN_INSTRUCTION && state_q == PDEC_RUN;
    endsequence

    property p_nmi_block;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and (EXIT_SOURCE_SELECT == PDEC_SRC_NMI && nmi_b_s) |=> !POWER_DOWN;
    endproperty
    a_nmi_block: assert property (p_nmi_block) else $error("Entry despite high interrupt pin"); // RULE_01

    property p_wake_block;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and (EXIT_SOURCE_SELECT == PDEC_SRC_PORT2 && wake_any) |=> !POWER_DOWN;
    endproperty
    a_wake_block: assert property (p_wake_block) else $error("Entry despite active wake pin"); // RULE_02

    property p_ignore_resume;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and blocked and !stall_fault |=> INSTR_IGNORED && FETCH_ENABLE
            ##1 (!INSTR_IGNORED || $past(POWER_DOWN_INSTRUCTION));
    endproperty
    a_ignore_resume: assert property (p_ignore_resume) else $error("Blocked instruction not ignored"); // RULE_03

    property p_normal_entry;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and !blocked |=> POWER_DOWN && !PERIPHERAL_CLOCK_ENABLE;
    endproperty
    a_normal_entry: assert property (p_normal_entry) else $error("Normal entry missed"); // RULE_04

    property p_quasi_fault;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and blocked and stall_fault |=> QUASI_IDLE && !FETCH_ENABLE;
    endproperty
    a_quasi_fault: assert property (p_quasi_fault) else $error("Quasi-idle not entered"); // RULE_05

    property p_write_fault;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and blocked and !FIXED_STEP and NEXT_CODE_EXTERNAL and PREV_EXTERNAL_WRITE |=> QUASI_IDLE;
    endproperty
    a_write_fault: assert property (p_write_fault) else $error("Write case not quasi-idle"); // RULE_06

    property p_quasi_periph;
        @(posedge REF_CLK) disable iff (!RST_B)
        QUASI_IDLE |-> PERIPHERAL_CLOCK_ENABLE && (WATCHDOG_RESET == (WATCHDOG_ENABLE && WATCHDOG_OVERFLOW));
    endproperty
    a_quasi_periph: assert property (p_quasi_periph) else $error("Peripherals stopped in quasi-idle"); // RULE_07

    property p_quasi_noirq;
        @(posedge REF_CLK) disable iff (!RST_B)
        QUASI_IDLE |-> !IRQ_SERVICE_ENABLE && !PERIPHERAL_TRANSFER_ENABLE;
    endproperty
    a_quasi_noirq: assert property (p_quasi_noirq) else $error("Interrupts served in quasi-idle"); // RULE_08

    property p_quasi_exit;
        @(posedge REF_CLK) disable iff (!RST_B)
        (QUASI_IDLE && !NMI_B) [*3] |=> POWER_DOWN;
    endproperty
    a_quasi_exit: assert property (p_quasi_exit) else $error("Interrupt low did not power down"); // RULE_09

    property p_fixed_never;
        @(posedge REF_CLK) disable iff (!RST_B)
        FIXED_STEP |-> !QUASI_IDLE;
    endproperty
    a_fixed_never: assert property (p_fixed_never) else $error("Fixed step reached quasi-idle"); // RULE_10

    property p_fixed_resume;
        @(posedge REF_CLK) disable iff (!RST_B)
        s_pd_request and blocked and (FIXED_STEP != 1'b0) |=> INSTR_IGNORED && FETCH_ENABLE && !QUASI_IDLE;
    endproperty
    a_fixed_resume: assert property (p_fixed_resume) else $error("Fixed step did not resume"); // RULE_10

endmodule // pdec_power_down_entry

/* pdec_sync.sv */
// Purpose : Two-flop synchroniser for a vector of asynchronous pins
// Assumes : Destination clock REF_CLK
// Notes   : First stage is read only by the second stage
module pdec_sync #(
    parameter int          W   = 1,
    parameter logic [15:0] RST = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Reset value is sliced from a 16-bit word, so wider vectors cannot be served
    if (W < 1 || W > 16) begin : g_bad_width
        $error("pdec_sync: width out of range");
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST[W-1:0];
            sync_q <= RST[W-1:0];
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule // pdec_sync

/* tb.sv */
// Purpose : Self-checking bench for the power-down entry control block
// Assumes : Faulty step in slot 0, corrected step in slot 1, shared inputs
// Notes   : Each trial resets, since power-down is left only by reset
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: output differs from model", $time); end end
module tb
    import pdec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, rst_b, pdi, sel, nmi_req_b, nmi_b, ext, mux, mttc, pw, wd_ovf, wd_en, blk, flt;
    logic [15:0] wake_req, wake, en, pol, r;
    logic [3:0]  lag;
    logic [1:0]  pd, qi, fe, ig, irq, pte, pce, wdr;
    int          bad_count, num_checks;

    // ****************************************
    // Clock, far side and the two steps
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    pdec_pin_model PINS (.clk(ref_clk), .nmi_req_b(nmi_req_b), .wake_req(wake_req), .lag(lag),
                         .nmi_b(nmi_b), .wake(wake));

    for (genvar g = 0; g < 2; g++) begin : g_dut
        pdec_power_down_entry #(.WAKE_W(PDEC_WAKE_W), .FIXED_STEP((g == 1) ? 1'b1 : 1'b0)) DUT (
            .REF_CLK(ref_clk), .RST_B(rst_b), .POWER_DOWN_INSTRUCTION(pdi),
            .EXIT_SOURCE_SELECT(sel), .NMI_B(nmi_b), .PORT_TWO_WAKE_PINS(wake),
            .WAKE_PIN_ENABLE(en), .WAKE_PIN_ACTIVE_HIGH(pol), .NEXT_CODE_EXTERNAL(ext),
            .BUS_MULTIPLEXED(mux), .MUX_TRISTATE_WAIT_CTRL(mttc), .PREV_EXTERNAL_WRITE(pw),
            .WATCHDOG_OVERFLOW(wd_ovf), .WATCHDOG_ENABLE(wd_en), .POWER_DOWN(pd[g]),
            .QUASI_IDLE(qi[g]), .FETCH_ENABLE(fe[g]), .INSTR_IGNORED(ig[g]),
            .IRQ_SERVICE_ENABLE(irq[g]), .PERIPHERAL_TRANSFER_ENABLE(pte[g]),
            .PERIPHERAL_CLOCK_ENABLE(pce[g]), .WATCHDOG_RESET(wdr[g]));
    end

    // ****************************************
    // Stimulus and model
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic trial();
        r = lfsr(r);
        sel = r[0];
        nmi_req_b = sel ? 1'b1 : r[1];
        {pw, mttc, mux, ext} = r[5:2];
        lag = {2'b00, r[7:6]};
        wd_en = r[8];
        r = lfsr(r);
        wake_req = r;
        r = lfsr(r);
        en = r & 16'h0003;  // Few pins enabled, so both outcomes stay likely
        r = lfsr(r);
        pol = r;
        blk = sel ? |(en & ~(wake_req ^ pol)) : nmi_req_b;
        flt = ext & ((mux & (mttc == PDEC_MTTW_ACTIVE)) | pw);
        rst_b = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 pdi = 1'b1;
        @(posedge ref_clk);
        #1 pdi = 1'b0;
        wd_ovf = 1'b1;
        `CHK(pd[0], !blk)
        `CHK(qi[0], blk & flt)
        `CHK({ig[0], fe[0]}, {2{blk & !flt}})
        `CHK(pce[0], blk)
        `CHK({irq[0], pte[0]}, {2{blk & !flt}})
        `CHK({qi[1], ig[1], pd[1]}, {1'b0, blk, !blk})
        `CHK({fe[1], irq[1], pte[1], pce[1]}, {4{blk}})
        #1 `CHK(wdr[0], wd_en & blk)
        `CHK(wdr[1], wd_en & blk)
        @(posedge ref_clk);
        #1 wd_ovf = 1'b0;
        if (blk & !flt) begin
            `CHK({ig[0], fe[0]}, 2'b01)
        end
        if (blk & flt) begin
            nmi_req_b = 1'b0;
            @(negedge nmi_b);
            repeat (2) @(posedge ref_clk);
            #1 `CHK(pd[0], 1'b0)
            @(posedge ref_clk);
            #1 `CHK({pd[0], qi[0]}, 2'b10)
        end
    endtask

    initial begin
        {rst_b, pdi, sel, ext, mux, pw, wd_ovf, wd_en} = '0;
        {nmi_req_b, mttc} = 2'b11;
        {wake_req, en} = '0;
        pol = 16'hffff;
        lag = 4'h0;
        r = 16'h0c02;
        bad_count = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        #1;
        repeat (60) trial();
        print_verdict();
    end

    // Trials take about 7 us; a hang is cut well beyond that
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule // tb
